// [logic/lcdc_regs.vh]
`ifndef LCDC_REGS_VH
`define LCDC_REGS_VH

// Register word indices; the APB byte address is four times the index.
`define LCDC_CTRL_IDX        8'hDC
`define LCDC_STAT_IDX        8'hDE
`define LCDC_RAM_FIRST_IDX   8'hE0
`define LCDC_RAM_LAST_IDX    8'hF7
`define LCDC_RAM_BYTES       24
`define LCDC_ROW_STRIDE      5'h06

// Control register fields and reset value.
`define LCDC_CTRL_RESET      8'h00
`define LCDC_DRV_LSB         0
`define LCDC_PRE_LSB         3
`define LCDC_DUTY_LSB        6

// Prescaler select codes.
`define LCDC_PRE_OFF         3'h0
`define LCDC_PRE_STANDBY     3'h1
`define LCDC_PRE_BAD_A       3'h2
`define LCDC_PRE_DIV32       3'h3
`define LCDC_PRE_DIV64       3'h4
`define LCDC_PRE_DIV128      3'h5
`define LCDC_PRE_DIV256      3'h6
`define LCDC_PRE_BAD_B       3'h7

// Drive frequency code that must not be used.
`define LCDC_DRV_BAD         3'h7

// Duty select codes.
`define LCDC_DUTY_4          2'h0
`define LCDC_DUTY_1          2'h1
`define LCDC_DUTY_2          2'h2
`define LCDC_DUTY_3          2'h3

// Status register bit positions.
`define LCDC_ST_RUN          0
`define LCDC_ST_MISS         1
`define LCDC_ST_COM_LSB      2
`define LCDC_ST_PHASE        4
`define LCDC_ST_HIZ          5
`define LCDC_ST_LOWZ         6

// Pin drive level codes.
`define LCDC_LVL_GND         2'b00
`define LCDC_LVL_THIRD       2'b01
`define LCDC_LVL_TWO_THIRDS  2'b10
`define LCDC_LVL_FULL        2'b11

// Timing.
`define LCDC_LOWZ_REF_CYCLES 4'h8
`define LCDC_CLK_PERIOD_NS   10
`define LCDC_SUPV_TIMEOUT_NS 61035
// Supervisor timeout in pclk cycles, rounded up, sized to match the 16-bit parameter.
`define LCDC_SUPV_CYCLES     16'h17D8

`endif

// [logic/lcdc_ram.v]
module lcdc_ram #(
  parameter DEPTH = 24
) (
  input  wire        pclk,
  input  wire        wr_en,
  input  wire [4:0]  wr_addr,
  input  wire [7:0]  wr_data,
  input  wire [4:0]  rd_addr,
  output wire [7:0]  rd_data,
  input  wire [4:0]  row_base,
  output wire [39:0] row_data
);

  reg [7:0] mem [0:DEPTH-1];

  // Memory is not reset so that software sees undefined contents, as a plain RAM would.
  always @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];

  // A second read port lets refresh run without ever holding off the bus.
  assign row_data = {mem[row_base + 5'h04], mem[row_base + 5'h03], mem[row_base + 5'h02],
                     mem[row_base + 5'h01], mem[row_base]};

endmodule

// [logic/lcdc_clkgen.v]
`include "lcdc_regs.vh"

module lcdc_clkgen #(
  parameter [15:0] SUPV_CYCLES = `LCDC_SUPV_CYCLES
) (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       main_tick,
  input  wire       standby_tick,
  input  wire [2:0] prescale_sel,
  input  wire [2:0] drive_sel,
  input  wire       restart,
  output reg        ref_tick_q,
  output reg        drive_edge_q,
  output reg        clock_missing_q
);

  reg  [7:0]  pre_cnt_q;
  reg  [7:0]  half_cnt_q;
  reg  [15:0] sup_cnt_q;
  wire [7:0]  pre_term;
  wire [7:0]  half_term;
  wire        main_sel;
  wire        src_tick;

  function [7:0] pre_terminal;
    input [2:0] code;
    begin
      case (code)
        `LCDC_PRE_DIV32:  pre_terminal = 8'h1F;
        `LCDC_PRE_DIV64:  pre_terminal = 8'h3F;
        `LCDC_PRE_DIV128: pre_terminal = 8'h7F;
        default:          pre_terminal = 8'hFF;
      endcase
    end
  endfunction

  // Half a drive period in reference ticks: every half period is one drive edge.
  function [7:0] half_terminal;
    input [2:0] code;
    begin
      case (code)
        3'h0:    half_terminal = 8'hFF;
        3'h1:    half_terminal = 8'hBF;
        3'h2:    half_terminal = 8'h7F;
        3'h3:    half_terminal = 8'h5F;
        3'h4:    half_terminal = 8'h3F;
        3'h5:    half_terminal = 8'h2F;
        default: half_terminal = 8'h1F;
      endcase
    end
  endfunction

  assign pre_term  = pre_terminal(prescale_sel);
  assign half_term = half_terminal(drive_sel);
  assign main_sel  = (prescale_sel >= `LCDC_PRE_DIV32) && (prescale_sel <= `LCDC_PRE_DIV256);
  assign src_tick  = ((prescale_sel == `LCDC_PRE_STANDBY) && standby_tick) ||
                     (main_sel && main_tick && (pre_cnt_q == pre_term));

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_q       <= 8'h00;
      half_cnt_q      <= 8'h00;
      sup_cnt_q       <= 16'h0000;
      ref_tick_q      <= 1'b0;
      drive_edge_q    <= 1'b0;
      clock_missing_q <= 1'b0;
    end else if (restart) begin
      pre_cnt_q       <= 8'h00;
      half_cnt_q      <= 8'h00;
      sup_cnt_q       <= 16'h0000;
      ref_tick_q      <= 1'b0;
      drive_edge_q    <= 1'b0;
      clock_missing_q <= 1'b0;
    end else begin
      ref_tick_q <= src_tick;
      if (main_sel && main_tick) begin
        pre_cnt_q <= (pre_cnt_q == pre_term) ? 8'h00 : pre_cnt_q + 8'h01;
      end
      drive_edge_q <= ref_tick_q && (half_cnt_q == half_term);
      if (ref_tick_q) begin
        half_cnt_q <= (half_cnt_q == half_term) ? 8'h00 : half_cnt_q + 8'h01;
      end
      if (ref_tick_q) begin
        sup_cnt_q       <= 16'h0000;
        clock_missing_q <= 1'b0;
      end else if (sup_cnt_q >= SUPV_CYCLES - 16'h0001) begin
        clock_missing_q <= 1'b1;
      end else begin
        sup_cnt_q <= sup_cnt_q + 16'h0001;
      end
    end
  end

endmodule

// [logic/lcdc_top.v]
`include "lcdc_regs.vh"

module lcdc_top #(
  parameter [15:0] SUPV_CYCLES = `LCDC_SUPV_CYCLES
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        main_tick,
  input  wire        standby_tick,
  output reg  [79:0] seg_level_q,
  output reg  [7:0]  com_level_q,
  output wire        high_impedance_divider,
  output wire        low_impedance_divider
);

  reg  [7:0]  ctrl_hold_q;
  reg  [7:0]  ctrl_act_q;
  reg  [1:0]  com_q;
  reg         phase_q;
  reg  [3:0]  lowz_cnt_q;
  reg  [79:0] seg_level_d;
  reg  [7:0]  com_level_d;
  wire [7:0]  word_idx;
  wire        aligned;
  wire        hit_ctrl;
  wire        hit_stat;
  wire        hit_ram;
  wire        mapped;
  wire        setup_ph;
  wire        access_ph;
  wire [7:0]  ram_off;
  wire [7:0]  ram_rd;
  wire [39:0] row_data;
  wire [4:0]  row_base;
  wire [1:0]  duty;
  wire [2:0]  pre_sel;
  wire [2:0]  drv_sel;
  wire [1:0]  last_com;
  wire        ref_tick;
  wire        drive_edge;
  wire        clock_missing;
  wire        cfg_valid;
  wire        running;
  wire        frame_end;
  wire        apply;
  wire        cfg_change;
  wire [7:0]  status;
  integer     k;

  // Active backplanes minus one for a duty code.
  function [1:0] last_backplane;
    input [1:0] code;
    begin
      case (code)
        `LCDC_DUTY_4: last_backplane = 2'h3;
        `LCDC_DUTY_1: last_backplane = 2'h0;
        `LCDC_DUTY_2: last_backplane = 2'h1;
        default:      last_backplane = 2'h2;
      endcase
    end
  endfunction

  // Segment level: lit pixels sit opposite the selected backplane, dark ones near it.
  function [1:0] seg_code;
    input       on;
    input       phase;
    input [1:0] code;
    begin
      if (on) begin
        seg_code = phase ? `LCDC_LVL_FULL : `LCDC_LVL_GND;
      end else if ((code == `LCDC_DUTY_1) || (code == `LCDC_DUTY_2)) begin
        seg_code = phase ? `LCDC_LVL_GND : `LCDC_LVL_FULL;
      end else begin
        seg_code = phase ? `LCDC_LVL_THIRD : `LCDC_LVL_TWO_THIRDS;
      end
    end
  endfunction

  // Backplane level; the half level of two-backplane mode uses the one-third tap,
  // which the board ties to the two-thirds tap.
  function [1:0] com_code;
    input       sel;
    input       used;
    input       phase;
    input [1:0] code;
    begin
      if (!used) begin
        com_code = `LCDC_LVL_GND;
      end else if (sel) begin
        com_code = phase ? `LCDC_LVL_GND : `LCDC_LVL_FULL;
      end else if (code == `LCDC_DUTY_2) begin
        com_code = `LCDC_LVL_THIRD;
      end else begin
        com_code = phase ? `LCDC_LVL_TWO_THIRDS : `LCDC_LVL_THIRD;
      end
    end
  endfunction

  assign word_idx  = paddr[9:2];
  assign aligned   = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  assign hit_ctrl  = aligned && (word_idx == `LCDC_CTRL_IDX);
  assign hit_stat  = aligned && (word_idx == `LCDC_STAT_IDX);
  assign hit_ram   = aligned && (word_idx >= `LCDC_RAM_FIRST_IDX) && (word_idx <= `LCDC_RAM_LAST_IDX);
  assign mapped    = hit_ctrl || hit_stat || hit_ram;
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign ram_off   = word_idx - `LCDC_RAM_FIRST_IDX;

  // Zero wait states: the slave always completes in the first access cycle.
  assign pready  = 1'b1;
  assign pslverr = access_ph && !mapped;

  assign duty    = ctrl_act_q[`LCDC_DUTY_LSB +: 2];
  assign pre_sel = ctrl_act_q[`LCDC_PRE_LSB +: 3];
  assign drv_sel = ctrl_act_q[`LCDC_DRV_LSB +: 3];

  assign last_com = last_backplane(duty);

  assign cfg_valid = (pre_sel != `LCDC_PRE_OFF) && (pre_sel != `LCDC_PRE_BAD_A) &&
                     (pre_sel != `LCDC_PRE_BAD_B) && (drv_sel != `LCDC_DRV_BAD);
  assign running   = cfg_valid && !clock_missing;

  assign frame_end = running && drive_edge && phase_q && (com_q == last_com);
  // apply held settings at frame end, or at once while not running
  assign apply     = frame_end || (!running && (ctrl_hold_q != ctrl_act_q));
  // Restarting only on a real change keeps the reference phase, so frames do not stretch every frame end.
  assign cfg_change = apply && (ctrl_hold_q != ctrl_act_q);

  // row of five bytes per backplane
  assign row_base = ({3'b000, com_q} * `LCDC_ROW_STRIDE) + 5'h01;

  assign status = {1'b0, low_impedance_divider, high_impedance_divider, phase_q, com_q, clock_missing, running};

  lcdc_ram #(
    .DEPTH (`LCDC_RAM_BYTES)
  ) u_ram (
    .pclk     (pclk),
    .wr_en    (access_ph && pwrite && hit_ram),
    .wr_addr  (ram_off[4:0]),
    .wr_data  (pwdata[7:0]),
    .rd_addr  (ram_off[4:0]),
    .rd_data  (ram_rd),
    .row_base (row_base),
    .row_data (row_data)
  );

  lcdc_clkgen #(
    .SUPV_CYCLES (SUPV_CYCLES)
  ) u_clkgen (
    .pclk            (pclk),
    .presetn         (presetn),
    .main_tick       (main_tick),
    .standby_tick    (standby_tick),
    .prescale_sel    (pre_sel),
    .drive_sel       (drv_sel),
    .restart         (cfg_change),
    .ref_tick_q      (ref_tick),
    .drive_edge_q    (drive_edge),
    .clock_missing_q (clock_missing)
  );

  // Read data is captured in the setup cycle so that it is a flip-flop output in the access cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_ph && !pwrite) begin
      if (hit_ctrl) begin
        prdata <= {24'h000000, ctrl_hold_q};
      end else if (hit_stat) begin
        prdata <= {24'h000000, status};
      end else if (hit_ram) begin
        prdata <= {24'h000000, ram_rd};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_hold_q <= `LCDC_CTRL_RESET;
      ctrl_act_q  <= `LCDC_CTRL_RESET;
      com_q       <= 2'h0;
      phase_q     <= 1'b0;
    end else begin
      if (access_ph && pwrite && hit_ctrl) begin
        ctrl_hold_q <= pwdata[7:0];
      end
      if (apply) begin
        ctrl_act_q <= ctrl_hold_q;
        com_q      <= 2'h0;
        phase_q    <= 1'b0;
      end else if (running && drive_edge) begin
        // two drive edges per backplane slot
        if (!phase_q) begin
          phase_q <= 1'b1;
        end else begin
          phase_q <= 1'b0;
          com_q   <= com_q + 2'h1;
        end
      end
    end
  end

  // low-impedance window of eight reference cycles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lowz_cnt_q <= 4'h0;
    end else if (!running) begin
      lowz_cnt_q <= 4'h0;
    end else if (drive_edge) begin
      lowz_cnt_q <= `LCDC_LOWZ_REF_CYCLES;
    end else if (ref_tick && (lowz_cnt_q != 4'h0)) begin
      lowz_cnt_q <= lowz_cnt_q - 4'h1;
    end
  end

  assign high_impedance_divider = running;
  assign low_impedance_divider  = running && (lowz_cnt_q != 4'h0);

  // refresh reads the second memory port
  always @* begin
    seg_level_d = 80'h0;
    com_level_d = 8'h00;
    if (running) begin
      for (k = 0; k < 40; k = k + 1) begin
        seg_level_d[2*k +: 2] = seg_code(row_data[k], phase_q, duty);
      end
      for (k = 0; k < 4; k = k + 1) begin
        com_level_d[2*k +: 2] = com_code(com_q == k[1:0], k[1:0] <= last_com, phase_q, duty);
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_level_q <= 80'h0;
      com_level_q <= 8'h00;
    end else begin
      seg_level_q <= seg_level_d;
      com_level_q <= com_level_d;
    end
  end

endmodule

// [dv/lcdc_sva.sv]
module lcdc_sva #(
  parameter [15:0] SUPV_CYCLES = 16'h17D8
) (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [79:0] seg_level_q,
  input wire [7:0]  com_level_q,
  input wire        high_impedance_divider,
  input wire        low_impedance_divider
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire hiz = high_impedance_divider;
  wire lowz = low_impedance_divider;

  a_zero_wait: assert property (acc |-> pready)
    else $error("pready low in access");
  a_misalign_err: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("no error on misaligned access");
  a_err_in_access: assert property (pslverr |-> acc)
    else $error("error outside access phase");
  a_err_read_zero: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_read_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_off_grounded: assert property (!hiz [*2] |-> seg_level_q == 80'h0 && com_level_q == 8'h0)
    else $error("outputs driven while off");
  a_lowz_needs_hiz: assert property (lowz |-> hiz)
    else $error("low divider on while off");
  a_lowz_window: assert property ($rose(lowz) |-> ##1 (lowz || !hiz) [*6])
    else $error("low divider window too short");
  a_reset_off: assert property ($rose(presetn) |-> !hiz ##1 !hiz)
    else $error("display on after reset");

  c_lowz: cover property ($rose(lowz));
  c_err: cover property (pslverr);
  c_run: cover property ($rose(hiz));
endmodule

bind lcdc_top lcdc_sva #(.SUPV_CYCLES(SUPV_CYCLES)) u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .seg_level_q(seg_level_q), .com_level_q(com_level_q),
  .high_impedance_divider(high_impedance_divider), .low_impedance_divider(low_impedance_divider)
);

// [dv/lcdc_panel.sv]
module lcdc_panel (
  input  wire [79:0] seg_level_q,
  input  wire [7:0]  com_level_q,
  output logic       stress
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb begin
    stress = 1'b0;
    for (int k = 0; k < 40; k++)
      for (int c = 0; c < 4; c++)
        if (seg_level_q[2*k +: 2] != com_level_q[2*c +: 2]) stress = 1'b1;
  end
endmodule

// [dv/tb_lcd_multiplex_controller.sv]
module tb_lcd_multiplex_controller;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic e; logic [31:0] m; logic [31:0] v;} lcdc_exp_t;
  logic        pclk, presetn, psel, penable, pwrite, main_tick, standby_tick, sb_en, mt_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, w;
  logic [7:0]  mem [24];
  logic [7:0]  bad [4] = '{8'h10, 8'h38, 8'h0F, 8'h00};
  wire         pready, pslverr, hiz, lowz, stress;
  wire  [31:0] prdata;
  wire  [79:0] seg;
  wire  [7:0]  com;
  lcdc_exp_t   q [$];
  lcdc_exp_t   x;
  int          n_mismatch, check_count, seed, sb_cnt, a, b;
  int          h [7] = '{256, 192, 128, 96, 64, 48, 32};

  lcdc_top #(.SUPV_CYCLES(16'h012C)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .main_tick(main_tick), .standby_tick(standby_tick), .seg_level_q(seg), .com_level_q(com),
    .high_impedance_divider(hiz), .low_impedance_divider(lowz));
  lcdc_panel u_panel (.seg_level_q(seg), .com_level_q(com), .stress(stress));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    sb_cnt <= (sb_cnt + 1) % 4;
    standby_tick <= sb_en && sb_cnt == 0;
    main_tick <= mt_en;
  end

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      x = q.pop_front();
      chk(96'({pslverr, prdata & x.m}), 96'({x.e, x.v & x.m}));
    end
  end

  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wn, input logic [11:0] ad, input logic [31:0] dt,
                     input logic e, input logic [31:0] m, input logic [31:0] v);
    @(posedge pclk);
    q.push_back(lcdc_exp_t'{e, m, v});
    psel <= 1'b1;
    pwrite <= wn;
    paddr <= ad;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] dt);
    apb(1'b1, ad, dt, 1'b0, 32'h0, 32'h0);
  endtask

  task automatic rd(input logic [11:0] ad, input logic [31:0] m, input logic [31:0] v);
    apb(1'b0, ad, 32'h0, 1'b0, m, v);
  endtask

  task automatic till(input logic v, output int n);
    n = 0;
    while (lowz !== v && n < 20000) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk(96'(n >= 20000), 96'(0));
  endtask

  // Expected levels of the first backplane slot in its second half.
  function automatic logic [87:0] lvl(input int bp);
    logic [87:0] e;
    e = 88'h0;
    for (int k = 0; k < 40; k++)
      e[2*k +: 2] = mem[1 + k / 8][k % 8] ? 2'b11 : (bp <= 2 ? 2'b00 : 2'b01);
    for (int c = 1; c < bp; c++)
      e[80 + 2*c +: 2] = bp == 2 ? 2'b01 : 2'b10;
    return e;
  endfunction

  task automatic run(input logic [7:0] cfg, input int sp, input int hp, input int bp);
    int   r, i;
    logic p;
    wr(12'h370, {24'h0, cfg});
    till(1'b1, a);
    repeat (2) @(posedge pclk);
    #1;
    chk(96'({com, seg}), 96'(lvl(bp)));
    till(1'b0, a);
    till(1'b1, b);
    chk(96'((a + 2 + sp / 2) / sp), 96'(8));
    chk(96'(a + 2 + b), 96'(hp * sp));
    wr(12'h370, 32'h0);
    rd(12'h378, 32'h21, 32'h21);
    r = 2;
    p = 1'b1;
    i = 0;
    while (hiz === 1'b1 && i < 20000) begin
      @(posedge pclk);
      #1;
      if (lowz === 1'b1 && p !== 1'b1) r++;
      p = lowz;
      i++;
    end
    chk(96'(i >= 20000), 96'(0));
    chk(96'((r + 1) % (2 * bp)), 96'(0));
    repeat (2) @(posedge pclk);
    #1;
    chk(96'({stress, com, seg, lowz}), 96'(0));
  endtask

  task automatic finish_test;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #950000;
    n_mismatch++;
    finish_test;
  end

  initial begin
    {presetn, psel, penable, pwrite, main_tick, standby_tick, sb_en, mt_en} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    sb_cnt = 0;
    seed = 882;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h370, 32'hFFFFFFFF, 32'h0);
    rd(12'h378, 32'hFFFFFFFF, 32'h0);
    apb(1'b0, 12'h004, 32'h0, 1'b1, 32'hFFFFFFFF, 32'h0);
    apb(1'b0, 12'h3E0, 32'h0, 1'b1, 32'hFFFFFFFF, 32'h0);
    apb(1'b1, 12'h371, 32'hFF, 1'b1, 32'h0, 32'h0);
    wr(12'h378, 32'hFF);
    rd(12'h378, 32'hFFFFFFFF, 32'h0);
    for (int i = 0; i < 24; i++) begin
      w = $random(seed);
      mem[i] = w[7:0];
      wr(12'h380 + 12'(4 * i), w);
    end
    for (int i = 0; i < 24; i++)
      rd(12'h380 + 12'(4 * i), 32'hFFFFFFFF, {24'h0, mem[i]});
    sb_en <= 1'b1;
    foreach (bad[i]) begin
      wr(12'h370, {24'h0, bad[i]});
      rd(12'h370, 32'hFF, {24'h0, bad[i]});
      rd(12'h378, 32'h21, 32'h0);
    end
    for (int i = 0; i < 7; i++)
      run({2'h1, 3'h1, 3'(i)}, 4, h[i], 1);
    for (int d = 0; d < 4; d++)
      if (d != 1) run({2'(d), 3'h1, 3'h6}, 4, 32, d == 0 ? 4 : d);
    sb_en <= 1'b0;
    mt_en <= 1'b1;
    for (int p = 3; p < 7; p++)
      run({2'h1, 3'(p), 3'h6}, 32 << (p - 3), 32, 1);
    mt_en <= 1'b0;
    sb_en <= 1'b1;
    wr(12'h370, 32'h4E);
    till(1'b1, a);
    sb_en <= 1'b0;
    repeat (340) @(posedge pclk);
    #1;
    chk(96'({stress, com, seg}), 96'(0));
    rd(12'h378, 32'h23, 32'h2);
    finish_test;
  end
endmodule
